// *** ee_i2c_eeprom.sv ***
// Purpose: Two-wire slave front end of a 2048-byte serial EEPROM.
// Assumes: SCL and SDA are oversampled by the 100 MHz system clock.
// Notes:   Open-drain pins are split into in, out and active-low enable.
//
// Summary of operation
// - START is SDA falling with SCL high; nothing is answered before one.
// - STOP is SDA rising with SCL high; master ends each operation so.
// - Address byte accepted only when its top nibble is the device type.
// - Next three address-byte bits are the top three array address bits.
// - Address byte bit zero selects read when one, write when zero.
// - Receiver of a byte pulls SDA low in the ninth clock.
// - Write mode acknowledges address, word address and each data byte it stores.
// - Read sends eight bits, then samples ack; no ack means wait for STOP.
// - Byte write loads word address, stores data, programs after STOP.
// - While programming, the device ignores the bus, even its own address.
// - Up to sixteen data bytes are buffered per write cycle.
// - Each written byte bumps only the in-page address bits.
// - Beyond sixteen bytes the page address wraps and overwrites.
// - Write protect acks address and word address, naks first data byte.
// - Counter holds last address plus one; current read returns it.
// - On reads the counter wraps from the top address to zero.
// - Sequential reads increment the full counter across all bits.
// - Manual reset senses only rising high pin or falling low pin edges.
// - A sensed edge holds the reset outputs for 200 ms, then releases.
// - Memory naks the address byte and data bytes while any reset pin is active.
// - Programming lasts from STOP up to ten milliseconds, bus disabled.
`timescale 1ns/1ps
module ee_i2c_eeprom #(
  parameter int PROG_CYCLES        = ee_pkg::EE_PROG_CYCLES,
  parameter int RST_STRETCH_CYCLES = ee_pkg::EE_STRETCH_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  input  wire logic wp_in,
  input  wire logic rst_hi_in,
  output logic      rst_hi_out,
  output logic      rst_hi_oe_n,
  input  wire logic rst_lo_n_in,
  output logic      rst_lo_n_out,
  output logic      rst_lo_n_oe_n,
  output logic      prog_busy
);
  import ee_pkg::*;

  localparam int FW = EE_ADDR_W + 8;
  localparam int PW = $clog2(PROG_CYCLES + 1);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] wp_sync_q;
  logic [1:0] rhi_sync_q;
  logic [1:0] rlo_sync_q;
  logic       scl_d1_q;
  logic       sda_d1_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      wp_sync_q  <= 2'h0;
      rhi_sync_q <= 2'h0;
      rlo_sync_q <= 2'h3;
      scl_d1_q   <= 1'b1;
      sda_d1_q   <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      wp_sync_q  <= {wp_sync_q[0], wp_in};
      rhi_sync_q <= {rhi_sync_q[0], rst_hi_in};
      rlo_sync_q <= {rlo_sync_q[0], rst_lo_n_in};
      scl_d1_q   <= scl_sync_q[1];
      sda_d1_q   <= sda_sync_q[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign scl_s    = scl_sync_q[1];
  assign sda_s    = sda_sync_q[1];
  assign wp_s     = wp_sync_q[1];
  assign scl_rise = scl_s && !scl_d1_q;
  assign scl_fall = !scl_s && scl_d1_q;
  assign start_ev = scl_s && scl_d1_q && sda_d1_q && !sda_s;
  assign stop_ev  = scl_s && scl_d1_q && !sda_d1_q && sda_s;

  // ---------------------------------------------------------------
  // Manual reset
  // ---------------------------------------------------------------
  logic stretch;
  logic mem_off;

  ee_rst_stretch #(
    .STRETCH_CYCLES (RST_STRETCH_CYCLES)
  ) u_stretch (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .hi_lvl    (rhi_sync_q[1]),
    .lo_n_lvl  (rlo_sync_q[1]),
    .stretch_q (stretch)
  );

  // Pins are treated as the reset condition too, so a held button stays effective.
  assign mem_off = stretch || rhi_sync_q[1] || !rlo_sync_q[1];

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rst_hi_oe_n   <= 1'b0;
      rst_lo_n_oe_n <= 1'b0;
    end else begin
      rst_hi_oe_n   <= !stretch;
      rst_lo_n_oe_n <= !stretch;
    end
  end

  assign rst_hi_out   = 1'b1;
  assign rst_lo_n_out = 1'b0;
  assign sda_out      = 1'b0;

  // ---------------------------------------------------------------
  // Array and write path
  // ---------------------------------------------------------------
  logic [7:0]           mem [EE_DEPTH];
  logic [7:0]           pbuf [1 << EE_PAGE_W];
  logic [15:0]          pval_q;
  logic [6:0]           page_hi_q;
  logic [EE_PAGE_W-1:0] idx_q;
  logic [PW-1:0]        pg_cnt_q;
  ee_pg_t               pg_q;

  ee_bus_t              st_q;
  ee_bus_t              next_q;
  logic [3:0]           bit_q;
  logic [7:0]           sh_q;
  logic [7:0]           tx_q;
  logic [2:0]           hi_q;
  logic [EE_ADDR_W-1:0] ptr_q;
  logic                 oe_q;
  logic                 mack_q;
  logic                 wr_pend_q;

  logic          push;
  logic          f_in_ready;
  logic          f_out_valid;
  logic          f_out_ready;
  logic [FW-1:0] f_out_data;
  logic          byte_end;
  logic          addr_end;
  logic          wdata_end;
  logic          addr_ok;
  logic [7:0]    rd_byte;

  assign byte_end  = scl_fall && bit_q == 4'h8;
  assign addr_end  = byte_end && st_q == ST_ADDR;
  assign wdata_end = byte_end && st_q == ST_WDATA;
  assign addr_ok   = sh_q[7:4] == EE_DEV_TYPE && !prog_busy && !mem_off;
  assign push      = wdata_end && !wp_s && !mem_off && f_in_ready;
  assign rd_byte   = mem[ptr_q];
  assign prog_busy = pg_q != PG_IDLE;
  // Draining halts while the page commits, so pbuf and pval_q hold still during the copy.
  assign f_out_ready = pg_q != PG_COMMIT;

  ee_fifo #(
    .W     (FW),
    .DEPTH (EE_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   ({ptr_q, sh_q}),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // Page buffer: later bytes at the same slot overwrite earlier ones.
  always_ff @(posedge sys_clk) begin
    if (f_out_valid && f_out_ready) begin
      pbuf[f_out_data[EE_PAGE_W+7:8]] <= f_out_data[7:0];
    end
    if (pg_q == PG_COMMIT && pval_q[idx_q]) begin
      mem[{page_hi_q, idx_q}] <= pbuf[idx_q];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pg_q      <= PG_IDLE;
      pval_q    <= 16'h0000;
      page_hi_q <= 7'h00;
      idx_q     <= '0;
      pg_cnt_q  <= '0;
    end else begin
      if (f_out_valid && f_out_ready) begin
        pval_q[f_out_data[EE_PAGE_W+7:8]] <= 1'b1;
        page_hi_q <= f_out_data[FW-1:EE_PAGE_W+8];
      end
      if (pg_q != PG_IDLE) pg_cnt_q <= pg_cnt_q + 1'b1;
      case (pg_q)
        PG_IDLE: begin
          pg_cnt_q <= '0;
          if (stop_ev && wr_pend_q) pg_q <= PG_DRAIN;
        end
        PG_DRAIN: begin
          if (!f_out_valid) pg_q <= PG_COMMIT;
        end
        PG_COMMIT: begin
          idx_q <= idx_q + 1'b1;
          if (idx_q == '1) begin
            pval_q <= 16'h0000;
            pg_q   <= PG_WAIT;
          end
        end
        PG_WAIT: begin
          if (pg_cnt_q >= PW'(PROG_CYCLES - 1)) pg_q <= PG_IDLE;
        end
        default: pg_q <= PG_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bus state machine
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q      <= ST_IDLE;
      next_q    <= ST_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      hi_q      <= 3'h0;
      ptr_q     <= '0;
      oe_q      <= 1'b1;
      mack_q    <= 1'b0;
      wr_pend_q <= 1'b0;
    end else if (start_ev) begin
      st_q  <= ST_ADDR;
      bit_q <= 4'h0;
      oe_q  <= 1'b1;
    end else if (stop_ev) begin
      st_q      <= ST_IDLE;
      oe_q      <= 1'b1;
      wr_pend_q <= 1'b0;
    end else if (scl_rise) begin
      if (st_q == ST_ADDR || st_q == ST_WADDR || st_q == ST_WDATA) begin
        sh_q  <= {sh_q[6:0], sda_s};
        bit_q <= bit_q + 1'b1;
      end
      if (st_q == ST_RACK) mack_q <= !sda_s;
    end else if (scl_fall) begin
      case (st_q)
        ST_ADDR: begin
          if (bit_q == 4'h8) begin
            if (addr_ok) begin
              oe_q   <= 1'b0;
              hi_q   <= sh_q[3:1];
              next_q <= sh_q[0] ? ST_TX : ST_WADDR;
              st_q   <= ST_ACK;
            end else begin
              st_q <= ST_WAIT;
            end
          end
        end
        ST_WADDR: begin
          if (bit_q == 4'h8) begin
            oe_q   <= 1'b0;
            ptr_q  <= {hi_q, sh_q};
            next_q <= ST_WDATA;
            st_q   <= ST_ACK;
          end
        end
        ST_WDATA: begin
          if (bit_q == 4'h8) begin
            if (push) begin
              oe_q       <= 1'b0;
              ptr_q[3:0] <= ptr_q[3:0] + 1'b1;
              wr_pend_q  <= 1'b1;
              st_q       <= ST_ACK;
            end else begin
              st_q <= ST_WAIT;
            end
          end
        end
        ST_ACK: begin
          bit_q <= 4'h0;
          if (next_q == ST_TX) begin
            oe_q  <= rd_byte[7];
            tx_q  <= {rd_byte[6:0], 1'b0};
            bit_q <= 4'h1;
            ptr_q <= ptr_q + 1'b1;
            st_q  <= ST_TX;
          end else begin
            oe_q <= 1'b1;
            st_q <= next_q;
          end
        end
        ST_TX: begin
          if (bit_q == 4'h8) begin
            oe_q <= 1'b1;
            st_q <= ST_RACK;
          end else begin
            oe_q  <= tx_q[7];
            tx_q  <= {tx_q[6:0], 1'b0};
            bit_q <= bit_q + 1'b1;
          end
        end
        ST_RACK: begin
          if (mack_q) begin
            oe_q  <= rd_byte[7];
            tx_q  <= {rd_byte[6:0], 1'b0};
            bit_q <= 4'h1;
            ptr_q <= ptr_q + 1'b1;
            st_q  <= ST_TX;
          end else begin
            oe_q <= 1'b1;
            st_q <= ST_WAIT;
          end
        end
        default: ;
      endcase
    end
  end

  assign sda_oe_n = oe_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_start_seen;
    @(posedge sys_clk) disable iff (reset)
      start_ev |=> st_q == ST_ADDR && bit_q == 4'h0 && sda_oe_n;
  endproperty
  a_start_seen: assert property (p_start_seen) else $error("start not taken");

  property p_stop_seen;
    @(posedge sys_clk) disable iff (reset)
      (stop_ev && !start_ev) |=> st_q == ST_IDLE && sda_oe_n && !wr_pend_q;
  endproperty
  a_stop_seen: assert property (p_stop_seen) else $error("stop not taken");

  property p_type_match;
    @(posedge sys_clk) disable iff (reset)
      (addr_end && !start_ev && !stop_ev && sh_q[7:4] != EE_DEV_TYPE)
        |=> sda_oe_n && st_q == ST_WAIT;
  endproperty
  a_type_match: assert property (p_type_match) else $error("foreign address acked");

  property p_busy_nak;
    @(posedge sys_clk) disable iff (reset)
      (addr_end && !start_ev && !stop_ev && (prog_busy || mem_off)) |=> sda_oe_n [*2];
  endproperty
  a_busy_nak: assert property (p_busy_nak) else $error("acked while disabled");

  property p_wp_nak;
    @(posedge sys_clk) disable iff (reset)
      (wdata_end && !start_ev && !stop_ev && wp_s) |=> sda_oe_n && st_q == ST_WAIT;
  endproperty
  a_wp_nak: assert property (p_wp_nak) else $error("protected data acked");

  property p_page_inc;
    @(posedge sys_clk) disable iff (reset)
      (push && !start_ev && !stop_ev) |=> ptr_q[10:4] == $past(ptr_q[10:4])
        && ptr_q[3:0] == $past(ptr_q[3:0]) + 4'h1 && !sda_oe_n;
  endproperty
  a_page_inc: assert property (p_page_inc) else $error("page address wrong");

  property p_seq_inc;
    @(posedge sys_clk) disable iff (reset)
      (scl_fall && !start_ev && !stop_ev && st_q == ST_RACK && mack_q)
        |=> ptr_q == $past(ptr_q) + 11'h001 && st_q == ST_TX;
  endproperty
  a_seq_inc: assert property (p_seq_inc) else $error("read counter wrong");

  property p_commit;
    @(posedge sys_clk) disable iff (reset)
      (stop_ev && wr_pend_q && pg_q == PG_IDLE) |=> prog_busy ##[1:40] pg_q == PG_WAIT;
  endproperty
  a_commit: assert property (p_commit) else $error("programming not started");

  property p_prog_len;
    @(posedge sys_clk) disable iff (reset)
      prog_busy |-> pg_cnt_q < PW'(PROG_CYCLES);
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("programming too long");

endmodule : ee_i2c_eeprom

// *** ee_pkg.sv ***
// Purpose: Shared constants and types for the serial EEPROM slave.
// Assumes: A 100 MHz system clock.
// Notes:   Long cycle counts are also exposed as top-level parameters.
package ee_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int         EE_ADDR_W     = 11;
  localparam int         EE_PAGE_W     = 4;
  localparam int         EE_DEPTH      = 2048;
  localparam logic [3:0] EE_DEV_TYPE   = 4'ha;
  localparam int         EE_FIFO_DEPTH = 16;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int EE_SYS_CLK_HZ = 100_000_000;
  localparam int EE_PROG_TIME_MS = 10;
  // A longest time, so the division rounds down.
  localparam int EE_PROG_CYCLES = EE_PROG_TIME_MS * (EE_SYS_CLK_HZ / 1000);
  localparam int EE_RESET_STRETCH_INTERVAL_MS = 200;
  localparam int EE_STRETCH_CYCLES =
    EE_RESET_STRETCH_INTERVAL_MS * (EE_SYS_CLK_HZ / 1000);

  // ---------------------------------------------------------------
  // State encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_WADDR = 3'h2,
    ST_WDATA = 3'h3,
    ST_ACK   = 3'h4,
    ST_TX    = 3'h5,
    ST_RACK  = 3'h6,
    ST_WAIT  = 3'h7
  } ee_bus_t;

  typedef enum logic [1:0] {
    PG_IDLE   = 2'h0,
    PG_DRAIN  = 2'h1,
    PG_COMMIT = 2'h2,
    PG_WAIT   = 2'h3
  } ee_pg_t;

endpackage : ee_pkg

// *** ee_fifo.sv ***
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   DEPTH must be a power of two.
`timescale 1ns/1ps
module ee_fifo #(
  parameter int W     = 19,
  parameter int DEPTH = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  import ee_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;

  assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (in_valid && in_ready) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) wr_q <= wr_q + 1'b1;
      if (out_valid && out_ready) rd_q <= rd_q + 1'b1;
    end
  end

endmodule : ee_fifo

// *** ee_rst_stretch.sv ***
// Purpose: Manual reset edge sensing and reset output stretching.
// Assumes: Pin levels arrive already synchronised to sys_clk.
// Notes:   The stretch also runs once after the system reset releases.
`timescale 1ns/1ps
module ee_rst_stretch #(
  parameter int STRETCH_CYCLES = ee_pkg::EE_STRETCH_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic hi_lvl,
  input  wire logic lo_n_lvl,
  output logic      stretch_q
);
  import ee_pkg::*;

  localparam int CW = $clog2(STRETCH_CYCLES + 1);

  logic          hi_d1_q;
  logic          lo_n_d1_q;
  logic [CW-1:0] cnt_q;
  logic          edge_hit;

  // Our own drive shows up on the pins, so edges during a stretch are ignored.
  assign edge_hit = (hi_lvl && !hi_d1_q) || (!lo_n_lvl && lo_n_d1_q);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hi_d1_q   <= 1'b0;
      lo_n_d1_q <= 1'b1;
    end else begin
      hi_d1_q   <= hi_lvl;
      lo_n_d1_q <= lo_n_lvl;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stretch_q <= 1'b1;
      cnt_q     <= '0;
    end else if (stretch_q) begin
      if (cnt_q == CW'(STRETCH_CYCLES - 1)) begin
        stretch_q <= 1'b0;
        cnt_q     <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end else if (edge_hit) begin
      stretch_q <= 1'b1;
    end
  end

  property p_stretch_end;
    @(posedge sys_clk) disable iff (reset)
      (stretch_q && cnt_q == CW'(STRETCH_CYCLES - 1)) |=> !stretch_q && cnt_q == '0;
  endproperty
  a_stretch_end: assert property (p_stretch_end) else $error("stretch not released");

  property p_edge_start;
    @(posedge sys_clk) disable iff (reset)
      (!stretch_q && edge_hit) |=> stretch_q && cnt_q == '0;
  endproperty
  a_edge_start: assert property (p_edge_start) else $error("edge did not start");

endmodule : ee_rst_stretch

// *** ee_i2c_master_model.sv ***
// Purpose: Behavioural two-wire bus master that drives the EEPROM slave.
// Assumes: SCL is held 4 sys_clk high and 4 low, an 80 ns period.
// Notes:   SDA has a pull-up, so the master only ever pulls it low.
`timescale 1ns/1ps
module ee_i2c_master_model (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  // SCL stands high between frames, as an idle bus needs.
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt

  // SDA is released while SCL is low first, so a repeated START works too.
  task automatic start();
    sda_pull <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(2);
    sda_pull <= 1'b1;
    wt(2);
    scl <= 1'b0;
    wt(2);
  endtask : start

  task automatic stop();
    sda_pull <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(2);
    sda_pull <= 1'b0;
    wt(4);
  endtask : stop

  task automatic bit_xfer(input logic b, output logic r);
    sda_pull <= ~b;
    wt(2);
    scl <= 1'b1;
    wt(2);
    r = sda;
    wt(2);
    scl <= 1'b0;
    wt(2);
  endtask : bit_xfer

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : wbyte

  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~ack, r);
  endtask : rbyte
endmodule : ee_i2c_master_model

// *** ee_i2c_eeprom_tb.sv ***
// Purpose: Self-checking bench for the serial EEPROM slave.
// Assumes: Short programming and stretch counts for simulation.
// Notes:   Pins are resolved here from every party's pull.
`timescale 1ns/1ps
module ee_i2c_eeprom_tb;
  import ee_pkg::*;
  // Long enough that an ack poll sent right after a STOP still meets a busy device.
  localparam int PROG = 200;
  localparam int STR  = 50;
  logic sys_clk, reset, wp_in, hi_drv, lo_pull, scl, sda_pull, sda, rst_hi, rst_lo_n;
  logic sda_out, sda_oe_n, rst_hi_out, rst_hi_oe_n, rst_lo_n_out, rst_lo_n_oe_n, prog_busy;
  int   err_total, comparisons;

  // ---------------------------------------------------------------
  // Wires and instances
  // ---------------------------------------------------------------
  assign sda      = ~(sda_pull | (~sda_oe_n & ~sda_out));
  assign rst_hi   = hi_drv | (~rst_hi_oe_n & rst_hi_out);
  assign rst_lo_n = ~(lo_pull | (~rst_lo_n_oe_n & ~rst_lo_n_out));

  ee_i2c_master_model m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  ee_i2c_eeprom #(.PROG_CYCLES(PROG), .RST_STRETCH_CYCLES(STR)) dut (
    .sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .wp_in(wp_in), .rst_hi_in(rst_hi), .rst_hi_out(rst_hi_out),
    .rst_hi_oe_n(rst_hi_oe_n), .rst_lo_n_in(rst_lo_n), .rst_lo_n_out(rst_lo_n_out),
    .rst_lo_n_oe_n(rst_lo_n_oe_n), .prog_busy(prog_busy));

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  function automatic logic [7:0] abyte(input logic [10:0] a, input logic rd);
    return {EE_DEV_TYPE, a[10:8], rd};
  endfunction : abyte

  task automatic send(input logic [7:0] d, input logic exp);
    logic ack;
    m.wbyte(d, ack);
    chk("ack", ack, exp);
  endtask : send

  task automatic rd(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    m.rbyte(ack, d);
    chk("read", d, exp);
  endtask : rd

  task automatic setp(input logic [10:0] a);
    m.start();
    send(abyte(a, 1'b0), 1'b1);
    send(a[7:0], 1'b1);
  endtask : setp

  // Programming must end within the count; a hang here is a fault.
  task automatic wait_prog();
    int n;
    n = 0;
    m.wt(3);
    while (prog_busy !== 1'b0 && n < PROG + 20) begin
      m.wt(1);
      n++;
    end
    chk("busy", prog_busy, 1'b0);
  endtask : wait_prog

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_type();
    m.start();
    send(8'h90, 1'b0);
    m.stop();
  endtask : t_type

  // Seventeen bytes from offset e wrap, the last overwriting offset e.
  task automatic t_page();
    setp(11'h53e);
    for (int i = 0; i < 17; i++) send(8'h40 + i[7:0], 1'b1);
    m.stop();
    m.wt(3);
    chk("busy", prog_busy, 1'b1);
    m.start();
    send(abyte(11'h0, 1'b0), 1'b0);
    m.stop();
    wait_prog();
  endtask : t_page

  task automatic t_read();
    setp(11'h530);
    m.start();
    send(abyte(11'h530, 1'b1), 1'b1);
    for (int k = 0; k < 15; k++) rd(k < 14, (k == 14) ? 8'h50 : 8'h42 + k[7:0]);
    m.wt(5);
    chk("sda_oe_n", sda_oe_n, 1'b1);
    m.stop();
    m.start();
    send(abyte(11'h0, 1'b1), 1'b1);
    rd(1'b0, 8'h41);
    m.stop();
  endtask : t_read

  task automatic t_wrap();
    setp(11'h7ff);
    send(8'h5a, 1'b1);
    m.stop();
    wait_prog();
    setp(11'h000);
    send(8'hc3, 1'b1);
    m.stop();
    wait_prog();
    setp(11'h7ff);
    m.start();
    send(abyte(11'h7ff, 1'b1), 1'b1);
    rd(1'b1, 8'h5a);
    rd(1'b0, 8'hc3);
    m.stop();
  endtask : t_wrap

  task automatic t_wp();
    wp_in <= 1'b1;
    setp(11'h000);
    send(8'h11, 1'b0);
    m.stop();
    m.wt(4);
    chk("busy", prog_busy, 1'b0);
    wp_in <= 1'b0;
    setp(11'h000);
    m.start();
    send(abyte(11'h0, 1'b1), 1'b1);
    rd(1'b0, 8'hc3);
    m.stop();
  endtask : t_wp

  // The high pin is held far past the stretch; its fall must not retrigger.
  task automatic t_mrst();
    hi_drv <= 1'b1;
    m.wt(6);
    chk("rst_lo_n_oe_n", rst_lo_n_oe_n, 1'b0);
    m.start();
    send(abyte(11'h0, 1'b0), 1'b0);
    m.stop();
    m.wt(STR);
    chk("rst_lo_n_oe_n", rst_lo_n_oe_n, 1'b1);
    m.start();
    send(abyte(11'h0, 1'b0), 1'b0);
    m.stop();
    hi_drv <= 1'b0;
    m.wt(8);
    chk("rst_lo_n_oe_n", rst_lo_n_oe_n, 1'b1);
    m.start();
    send(abyte(11'h0, 1'b0), 1'b1);
    m.stop();
    lo_pull <= 1'b1;
    m.wt(6);
    chk("rst_hi_oe_n", rst_hi_oe_n, 1'b0);
    lo_pull <= 1'b0;
    m.wt(STR + 10);
    chk("rst_hi_oe_n", rst_hi_oe_n, 1'b1);
  endtask : t_mrst

  // ---------------------------------------------------------------
  // Sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    reset       = 1'b1;
    wp_in       = 1'b0;
    hi_drv      = 1'b0;
    lo_pull     = 1'b0;
    err_total   = 0;
    comparisons = 0;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (STR + 20) @(posedge sys_clk);
    t_type();
    t_page();
    t_read();
    t_wrap();
    t_wp();
    t_mrst();
    end_of_test();
  end

  // The tests need about 5400 cycles; about six times that means a hang.
  initial begin
    #320000;
    err_total++;
    end_of_test();
  end
endmodule : ee_i2c_eeprom_tb
